// ==== common/cam_status_pkg.sv ====
package cam_status_pkg;

    // axi4-lite register byte addresses
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] ACQ_ADDR = 8'h04;
    localparam logic [7:0] STAT_ADDR = 8'h08;
    localparam logic [7:0] EVT_ADDR = 8'h0c;

    // ctrl register fields
    localparam int SEL_LSB = 0;
    localparam int SEL_W = 3;
    localparam int POL_BIT = 4;
    localparam int VIDEO_BIT = 5;
    localparam int SYNC_EN_BIT = 6;

    // acq register: frame count, zero means free run
    localparam int FRAMES_W = 16;

    // acq command write bits
    localparam int CMD_START_BIT = 16;
    localparam int CMD_HALT_BIT = 17;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SRC_ACQ_PENDING = 3'h0,
        SRC_READOUT = 3'h1,
        SRC_SHUTTER = 3'h2,
        SRC_CLEANING = 3'h3,
        SRC_FT_SHIFT = 3'h4,
        SRC_LOGIC0 = 3'h5,
        SRC_LOGIC1 = 3'h6
    } src_sel_e;

    localparam logic [2:0] SEL_RESET = 3'h0;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
    } axi_word_s;

    typedef struct packed {
        logic clean;
        logic readout;
        logic shutter;
        logic ft_shift;
        logic exposure_start;
        logic frame_done;
    } cam_state_s;

endpackage

// ==== hw/camera_status_output_select.sv ====
// Contract
// - the status output shows exactly one software-selected camera state.
// - acq_pending_n is high from start through cleaning, low at first exposure.
// - in free run acq_pending_n stays low until software halts.
// - with a frame count it stays low until the last frame, then goes high.
// - readout_inactive is high when idle and low while readout runs.
// - readout_inactive is also low during every array cleaning.
// - shutter is low when closed and high while the shutter is active.
// - in gated mode shutter stays inactive during readout to inhibit a pulser.
// - cleaning is high only while an array clean cycle runs.
// - frame_transfer_shift_n is low during a shift, high otherwise.
// - selections 5 and 7 force the output to constant low, selection 6 to constant high.
// - sync events, not acquisition, are raised by edges on the trigger input of chosen sense.
// - composite video is enabled only when software selects it.
`timescale 1ns/1ps
`default_nettype none
module camera_status_output_select
    import cam_status_pkg::*;
(
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic [31:0] AWADDR_I,
    input wire logic AWVALID_I,
    output logic AWREADY_O,
    input wire logic [31:0] WDATA_I,
    input wire logic [3:0] WSTRB_I,
    input wire logic WVALID_I,
    output logic WREADY_O,
    output logic [1:0] BRESP_O,
    output logic BVALID_O,
    input wire logic BREADY_I,
    input wire logic [31:0] ARADDR_I,
    input wire logic ARVALID_I,
    output logic ARREADY_O,
    output logic [31:0] RDATA_O,
    output logic [1:0] RRESP_O,
    output logic RVALID_O,
    input wire logic RREADY_I,
    input wire logic CLEAN_ACTIVE_I,
    input wire logic READOUT_ACTIVE_I,
    input wire logic SHUTTER_OPEN_I,
    input wire logic FT_SHIFT_ACTIVE_I,
    input wire logic EXPOSURE_START_I,
    input wire logic FRAME_DONE_I,
    input wire logic GATED_MODE_I,
    input wire logic EXTERNAL_TRIGGER_INPUT_I,
    output logic SYNC_EVENT_O,
    output logic ACQ_RUN_O,
    output logic VIDEO_EN_O,
    output logic LOGIC_OUT_O
);

    typedef enum logic [2:0] {
        ACQ_IDLE = 3'b001,
        ACQ_CLEANING = 3'b010,
        ACQ_EXPOSING = 3'b100
    } acq_e;

    typedef struct packed {
        logic aw_have;
        logic w_have;
        axi_word_s aw;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [SEL_W-1:0] sel;
        logic pol;
        logic video;
        logic sync_en;
        logic [FRAMES_W-1:0] frames;
        logic [FRAMES_W-1:0] remaining;
        acq_e acq;
        logic trig_prev;
        logic sync_pulse;
        logic logic_out;
        logic [1:0] evt;
    } state_s;

    state_s st_q;
    state_s st_d;

    logic acq_pending_n;
    logic readout_inactive;
    logic shutter;
    logic cleaning;
    logic frame_transfer_shift_n;
    logic status_mux;
    logic trig_level;
    logic [31:0] ctrl_word;
    logic [31:0] merged;
    logic wr_fire;
    logic start_cmd;
    logic halt_cmd;

    assign acq_pending_n = (st_q.acq != ACQ_EXPOSING);
    assign readout_inactive = ~(READOUT_ACTIVE_I | CLEAN_ACTIVE_I);
    assign shutter = SHUTTER_OPEN_I & ~(GATED_MODE_I & READOUT_ACTIVE_I);
    assign cleaning = CLEAN_ACTIVE_I;
    assign frame_transfer_shift_n = ~FT_SHIFT_ACTIVE_I;
    assign trig_level = EXTERNAL_TRIGGER_INPUT_I ^ st_q.pol;

    assign ctrl_word = {25'h0, st_q.sync_en, st_q.video, st_q.pol, 1'b0,
                        st_q.sel};

    always_comb begin
        case (st_q.sel)
            SRC_ACQ_PENDING: status_mux = acq_pending_n;
            SRC_READOUT: status_mux = readout_inactive;
            SRC_SHUTTER: status_mux = shutter;
            SRC_CLEANING: status_mux = cleaning;
            SRC_FT_SHIFT: status_mux = frame_transfer_shift_n;
            SRC_LOGIC0: status_mux = 1'b0;
            SRC_LOGIC1: status_mux = 1'b1;
            default: status_mux = 1'b0;
        endcase
    end

    always_comb begin
        st_d = st_q;
        st_d.sync_pulse = 1'b0;
        // raw level kept so a polarity rewrite cannot fake an edge
        st_d.trig_prev = EXTERNAL_TRIGGER_INPUT_I;
        st_d.logic_out = status_mux;
        start_cmd = 1'b0;
        halt_cmd = 1'b0;
        merged = 32'h0;

        if (AWVALID_I && !st_q.aw_have) begin
            st_d.aw_have = 1'b1;
            st_d.aw.addr = AWADDR_I;
        end
        if (WVALID_I && !st_q.w_have) begin
            st_d.w_have = 1'b1;
            st_d.wdata = WDATA_I;
            st_d.wstrb = WSTRB_I;
        end
        wr_fire = st_q.aw_have && st_q.w_have && !st_q.bvalid;
        if (wr_fire) begin
            st_d.aw_have = 1'b0;
            st_d.w_have = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = RESP_OKAY;
            case (st_q.aw.addr[7:0])
                CTRL_ADDR: begin
                    if (st_q.wstrb[0]) begin
                        st_d.sel = st_q.wdata[SEL_LSB +: SEL_W];
                        st_d.pol = st_q.wdata[POL_BIT];
                        st_d.video = st_q.wdata[VIDEO_BIT];
                        st_d.sync_en = st_q.wdata[SYNC_EN_BIT];
                    end
                end
                ACQ_ADDR: begin
                    merged = {16'h0, st_q.frames};
                    if (st_q.wstrb[0]) merged[7:0] = st_q.wdata[7:0];
                    if (st_q.wstrb[1]) merged[15:8] = st_q.wdata[15:8];
                    st_d.frames = merged[FRAMES_W-1:0];
                    start_cmd = st_q.wstrb[2] && st_q.wdata[CMD_START_BIT];
                    halt_cmd = st_q.wstrb[2] && st_q.wdata[CMD_HALT_BIT];
                end
                STAT_ADDR, EVT_ADDR: ;
                default: st_d.bresp = RESP_SLVERR;
            endcase
        end
        if (st_q.bvalid && BREADY_I) begin
            st_d.bvalid = 1'b0;
        end

        if (ARVALID_I && !st_q.rvalid) begin
            st_d.rvalid = 1'b1;
            st_d.rresp = RESP_OKAY;
            case (ARADDR_I[7:0])
                CTRL_ADDR: st_d.rdata = ctrl_word;
                ACQ_ADDR: st_d.rdata = {16'h0, st_q.frames};
                STAT_ADDR: st_d.rdata = {25'h0, st_q.acq, frame_transfer_shift_n,
                                         cleaning, shutter, readout_inactive};
                EVT_ADDR: st_d.rdata = {30'h0, st_q.evt};
                default: begin
                    st_d.rdata = 32'h0;
                    st_d.rresp = RESP_SLVERR;
                end
            endcase
        end else if (st_q.rvalid && RREADY_I) begin
            st_d.rvalid = 1'b0;
        end

        if (st_q.sync_en && trig_level && !(st_q.trig_prev ^ st_q.pol)) begin
            st_d.sync_pulse = 1'b1;
            st_d.evt[0] = 1'b1;
        end

        case (st_q.acq)
            ACQ_IDLE: begin
                if (start_cmd) begin
                    st_d.acq = ACQ_CLEANING;
                    // count written with the start takes effect at once
                    st_d.remaining = st_d.frames;
                end
            end
            ACQ_CLEANING: begin
                if (halt_cmd) begin
                    st_d.acq = ACQ_IDLE;
                end else if (EXPOSURE_START_I) begin
                    st_d.acq = ACQ_EXPOSING;
                end
            end
            ACQ_EXPOSING: begin
                if (halt_cmd) begin
                    st_d.acq = ACQ_IDLE;
                end else if (FRAME_DONE_I && st_q.frames != '0) begin
                    st_d.remaining = st_q.remaining - 16'h1;
                    if (st_q.remaining <= 16'h1) begin
                        st_d.acq = ACQ_IDLE;
                        st_d.evt[1] = 1'b1;
                    end
                end
            end
            default: st_d.acq = ACQ_IDLE;
        endcase
    end

    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            st_q <= '0;
            st_q.sel <= SEL_RESET;
            st_q.acq <= ACQ_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    assign AWREADY_O = ~st_q.aw_have;
    assign WREADY_O = ~st_q.w_have;
    assign BVALID_O = st_q.bvalid;
    assign BRESP_O = st_q.bresp;
    assign ARREADY_O = ~st_q.rvalid;
    assign RVALID_O = st_q.rvalid;
    assign RDATA_O = st_q.rdata;
    assign RRESP_O = st_q.rresp;
    assign SYNC_EVENT_O = st_q.sync_pulse;
    assign ACQ_RUN_O = (st_q.acq != ACQ_IDLE);
    assign VIDEO_EN_O = st_q.video;
    assign LOGIC_OUT_O = st_q.logic_out;

endmodule
`default_nettype wire

// ==== dv/cam_status_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module cam_status_asserts (
    input wire logic CLK_I, NRST_I, AWVALID_I, AWREADY_O, WVALID_I,
    input wire logic WREADY_O, BVALID_O, BREADY_I, ARVALID_I, ARREADY_O,
    input wire logic RVALID_O, RREADY_I, FRAME_DONE_I, SYNC_EVENT_O,
    input wire logic EXTERNAL_TRIGGER_INPUT_I, ACQ_RUN_O,
    input wire logic [31:0] RDATA_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);
    sequence s_wr_taken;
        AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
    endsequence
    sequence s_trig_edge;
        $past(EXTERNAL_TRIGGER_INPUT_I) != $past(EXTERNAL_TRIGGER_INPUT_I, 2);
    endsequence
    a_write_answer: assert property (s_wr_taken |-> ##[1:2] BVALID_O)
        else $error("write response missing");
    a_b_hold: assert property (BVALID_O && !BREADY_I |=> BVALID_O)
        else $error("write response dropped early");
    a_r_hold: assert property (RVALID_O && !RREADY_I |=>
        RVALID_O && $stable(RDATA_O)) else $error("read data not held");
    a_ar_busy: assert property (RVALID_O |-> !ARREADY_O)
        else $error("read address taken while busy");
    a_read_answer: assert property (ARVALID_I && ARREADY_O |=> RVALID_O)
        else $error("read response missing");
    a_sync_cause: assert property (SYNC_EVENT_O |-> s_trig_edge)
        else $error("sync event without trigger edge");
    a_sync_single: assert property (SYNC_EVENT_O |=> !SYNC_EVENT_O)
        else $error("sync event longer than one cycle");
    a_run_end: assert property ($fell(ACQ_RUN_O) |-> $past(FRAME_DONE_I)
        || $past(WVALID_I) || $past(WVALID_I, 2))
        else $error("acquisition ended without cause");
endmodule
bind camera_status_output_select cam_status_asserts u_chk (.*);
`default_nettype wire

// ==== dv/external_trigger_input_source.sv ====
`timescale 1ns/1ps
`default_nettype none
module external_trigger_input_source (
    input wire logic clk_i,
    input wire logic flip_i,
    output logic trig_o
);
    initial trig_o = 1'h0;
    // outside party supplies sync edges on request
    always @(posedge clk_i) begin
        if (flip_i) begin
            trig_o <= ~trig_o;
        end
    end
endmodule
`default_nettype wire

// ==== dv/tb_camera_status_output_select.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_camera_status_output_select;
    import cam_status_pkg::*;
    logic clk = 1'h0, nrst = 1'h0, awv = 1'h0, wv = 1'h0, br = 1'h0;
    logic arv = 1'h0, rr = 1'h0, flip = 1'h0;
    logic [31:0] awa = '0, wd = '0, ara = '0, rdata;
    // clean readout shutter ft expo fdone gated
    logic [6:0] cam = '0;
    logic trig, sev, run, ven, lout, awr, wr_rdy, bv, arr, rv;
    logic [1:0] bresp, rresp;
    logic [31:0] rd_q[$];
    logic [1:0] rresp_q[$];
    int num_errors = 0, total_checks = 0, n_sync = 0;
    always #50 clk = ~clk;
    camera_status_output_select dut (.CLK_I(clk), .NRST_I(nrst),
        .AWADDR_I(awa), .AWVALID_I(awv), .AWREADY_O(awr), .WDATA_I(wd),
        .WSTRB_I(4'hf), .WVALID_I(wv), .WREADY_O(wr_rdy), .BRESP_O(bresp),
        .BVALID_O(bv), .BREADY_I(br), .ARADDR_I(ara), .ARVALID_I(arv),
        .ARREADY_O(arr), .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rv),
        .RREADY_I(rr), .CLEAN_ACTIVE_I(cam[6]), .READOUT_ACTIVE_I(cam[5]),
        .SHUTTER_OPEN_I(cam[4]), .FT_SHIFT_ACTIVE_I(cam[3]),
        .EXPOSURE_START_I(cam[2]), .FRAME_DONE_I(cam[1]),
        .GATED_MODE_I(cam[0]), .EXTERNAL_TRIGGER_INPUT_I(trig),
        .SYNC_EVENT_O(sev), .ACQ_RUN_O(run), .VIDEO_EN_O(ven),
        .LOGIC_OUT_O(lout));
    external_trigger_input_source u_src (.clk_i(clk), .flip_i(flip), .trig_o(trig));
    task automatic chk_word(input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic wr(input logic [31:0] a, d);
        int n;
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'h1;
        wv <= 1'h1;
        br <= 1'h1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (awv && awr) awv <= 1'h0;
            if (wv && wr_rdy) wv <= 1'h0;
        end while (!(bv && br) && n < 100);
        br <= 1'h0;
    endtask
    task automatic rd(input logic [31:0] a, exp);
        int n;
        rd_q.push_back(exp);
        rresp_q.push_back((a[7:0] > EVT_ADDR || a[1:0] != 2'h0) ?
                          RESP_SLVERR : RESP_OKAY);
        @(posedge clk);
        ara <= a;
        arv <= 1'h1;
        rr <= 1'h1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (arv && arr) arv <= 1'h0;
        end while (!(rv && rr) && n < 100);
        rr <= 1'h0;
    endtask
    task automatic pulse(input int b);
        @(posedge clk);
        cam[b] <= 1'h1;
        @(posedge clk);
        cam[b] <= 1'h0;
        tick(3);
    endtask
    task automatic flip_trig;
        @(posedge clk);
        flip <= 1'h1;
        @(posedge clk);
        flip <= 1'h0;
        tick(4);
    endtask
    function automatic logic exp_out(input int s, input logic [6:0] c);
        case (s)
            0: return 1'h1;
            1: return !(c[5] || c[6]);
            2: return c[4] && !(c[0] && c[5]);
            3: return c[6];
            4: return !c[3];
            6: return 1'h1;
            default: return 1'h0;
        endcase
    endfunction
    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        if (rv && rr) chk_word(rdata, rd_q.pop_front());
        if (rv && rr) chk_word({30'h0, rresp}, {30'h0, rresp_q.pop_front()});
        if (bv && br) chk_word({30'h0, bresp}, {30'h0, RESP_OKAY});
        if (sev === 1'h1) n_sync++;
    end
    initial begin
        #400000;
        num_errors++;
        give_verdict();
    end
    initial begin
        void'($urandom(5582));
        tick(12);
        nrst <= 1'h1;
        tick(2);
        rd(32'(CTRL_ADDR), 32'h0);
        rd(32'h10, 32'h0);
        for (int s = 0; s < 8; s++) begin
            wr(32'(CTRL_ADDR), s);
            for (int i = 0; i < 6; i++) begin
                @(posedge clk);
                cam <= 7'($urandom) & 7'h79;
                tick(3);
                chk_bit(lout, exp_out(s, cam));
            end
        end
        cam <= '0;
        wr(32'(CTRL_ADDR), 32'h0);
        rd(32'(STAT_ADDR), 32'h19);
        wr(32'(ACQ_ADDR), 32'h10002);
        tick(3);
        chk_bit(lout, 1'h1);
        chk_bit(run, 1'h1);
        pulse(2);
        chk_bit(lout, 1'h0);
        pulse(1);
        chk_bit(lout, 1'h0);
        pulse(1);
        chk_bit(lout, 1'h1);
        chk_bit(run, 1'h0);
        wr(32'(ACQ_ADDR), 32'h10000);
        pulse(2);
        for (int i = 0; i < 3; i++) begin
            pulse(1);
            chk_bit(lout, 1'h0);
        end
        wr(32'(ACQ_ADDR), 32'h20000);
        tick(3);
        chk_bit(lout, 1'h1);
        for (int p = 0; p < 2; p++) begin
            wr(32'(CTRL_ADDR), 32'h40 | (p << 4) | (p << 5));
            rd(32'(CTRL_ADDR), 32'h40 | (p << 4) | (p << 5));
            chk_bit(ven, 1'(p));
            n_sync = 0;
            flip_trig();
            chk_word(n_sync, 32'(p == 0));
            flip_trig();
            chk_word(n_sync, 32'h1);
        end
        rd(32'(EVT_ADDR), 32'h3);
        give_verdict();
    end
endmodule
`default_nettype wire
